// file: rtl/spdc_ctrl.sv
`timescale 1ns/10ps
`include "spdc_defines.svh"
module spdc_ctrl
  import spdc_pkg::*;
#(
  parameter logic [7:0] HALF = 8'(`SPDC_HALF_CYC)
)(
  // Serial link and polarity select
  spdc_if.ctrl        link,
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_b,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);

  spdc_ctl_type r;
  spdc_ctl_type n;
  logic         tick;

  // Half-period enable of the serial clock divider
  assign tick = (r.half_cnt == HALF - 8'h01);

  // Next state
  always_comb begin
    n = r;
    n.rdata = 32'h0;

    // ****************************************
    // Register writes
    // ****************************************
    if (wr) begin
      unique case (addr)
        `SPDC_OFS_WORD: begin
          n.word = wdata[23:0];
        end
        `SPDC_OFS_CTRL: begin
          n.pol_low = wdata[`SPDC_CTRL_POL];
          if (wdata[`SPDC_CTRL_CLR]) begin
            n.done = 1'b0;
            n.err  = 1'b0;
          end
          if (wdata[`SPDC_CTRL_GO] && r.state == spdc_idle) begin
            if (r.word[`SPDC_MAIN_MSB:`SPDC_MAIN_LSB] < `SPDC_MAIN_MIN) begin
              n.err = 1'b1;
            end else begin
              n.sh       = r.word;
              n.sdat     = r.word[23];
              n.bit_cnt  = 5'h00;
              n.half_cnt = 8'h00;
              n.sclk     = 1'b0;
              n.state    = spdc_lo;
            end
          end
        end
        default: begin
          n.word = r.word;
        end
      endcase
    end

    // ****************************************
    // Serial sequencer
    // ****************************************
    if (r.state != spdc_idle) begin
      n.half_cnt = tick ? 8'h00 : r.half_cnt + 8'h01;
    end
    unique case (r.state)
      spdc_idle: begin
        n.le = 1'b0;
      end
      spdc_lo: if (tick) begin
        n.sclk  = 1'b1;
        n.state = spdc_hi;
      end
      spdc_hi: if (tick) begin
        n.sclk = 1'b0;
        if (r.bit_cnt == `SPDC_LAST_BIT) begin
          n.le    = 1'b1;
          n.state = spdc_load;
        end else begin
          n.bit_cnt = r.bit_cnt + 5'h01;
          n.sh      = {r.sh[22:0], 1'b0};
          n.sdat    = r.sh[22];
          n.state   = spdc_lo;
        end
      end
      spdc_load: if (tick) begin
        n.le    = 1'b0;
        n.done  = 1'b1; // Set wins over clear
        n.state = spdc_idle;
      end
    endcase

    // ****************************************
    // Register reads
    // ****************************************
    if (rd) begin
      unique case (addr)
        `SPDC_OFS_WORD: begin
          n.rdata = {8'h00, r.word};
        end
        `SPDC_OFS_CTRL: begin
          n.rdata[`SPDC_CTRL_POL] = r.pol_low;
        end
        `SPDC_OFS_STATUS: begin
          n.rdata[`SPDC_STAT_BUSY] = (r.state != spdc_idle);
          n.rdata[`SPDC_STAT_DONE] = r.done;
          n.rdata[`SPDC_STAT_ERR]  = r.err;
        end
        default: begin
          n.rdata = 32'h0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r       <= '0;
      r.state <= spdc_idle;
    end else begin
      r <= n;
    end
  end

  // Link drive; polarity pin driven low or left open
  assign link.ser_clk     = r.sclk;
  assign link.ser_data    = r.sdat;
  assign link.load_strobe = r.le;
  assign link.pol_out     = 1'b0;
  assign link.pol_oe      = r.pol_low;
  assign rdata            = r.rdata;

endmodule // spdc_ctrl

// file: rtl/spdc_defines.svh
`ifndef SPDC_DEFINES_SVH
`define SPDC_DEFINES_SVH

// ****************************************
// Programming word layout
// ****************************************
`define SPDC_WORD_W      24
`define SPDC_MAIN_MSB    23
`define SPDC_MAIN_LSB    12
`define SPDC_SWAL_MSB    11
`define SPDC_SWAL_LSB    7
`define SPDC_REF_MSB     6
`define SPDC_REF_LSB     5
`define SPDC_PSEL_BIT    4
`define SPDC_BAND_MSB    3
`define SPDC_BAND_LSB    0
`define SPDC_LAST_BIT    5'h17
`define SPDC_LATCH_RST   24'h020000
`define SPDC_MAIN_MIN    12'h020

// ****************************************
// Divider ratios
// ****************************************
`define SPDC_PRE_LOW     10'h100
`define SPDC_PRE_HIGH    10'h200
`define SPDC_SWAL_STEP   10'h010
`define SPDC_REF_R0      12'h100
`define SPDC_REF_R1      12'h200
`define SPDC_REF_R2      12'h400
`define SPDC_REF_R3      12'h800

// ****************************************
// Controller registers
// ****************************************
`define SPDC_OFS_WORD    4'h0
`define SPDC_OFS_CTRL    4'h4
`define SPDC_OFS_STATUS  4'h8
`define SPDC_CTRL_GO     0
`define SPDC_CTRL_POL    1
`define SPDC_CTRL_CLR    2
`define SPDC_STAT_BUSY   0
`define SPDC_STAT_DONE   1
`define SPDC_STAT_ERR    2

// ****************************************
// Timing
// ****************************************
`define SPDC_SYS_CLK_NS    100
`define SPDC_SCLK_HALF_NS  400
`define SPDC_HALF_CYC      (`SPDC_SCLK_HALF_NS / `SPDC_SYS_CLK_NS)

`endif

// file: rtl/spdc_device.sv
`timescale 1ns/10ps
`include "spdc_defines.svh"
module spdc_device
  import spdc_pkg::*;
(
  // Serial link and polarity select
  spdc_if.dev        link,
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  // Pulse inputs from oscillator and prescaler input
  input  wire logic  osc_in,
  input  wire logic  vco_in,
  // Charge pump pins
  output logic [1:0] cp_out,
  output logic [1:0] cp_oe,
  // Lock and monitor
  output logic       lock_indicator,
  output logic       monitor_out,
  // Open-collector band outputs
  output logic [3:0] band_out,
  output logic [3:0] band_oe
);

  // ****************************************
  // Ratio decoding
  // ****************************************

  // Reference ratio from the two select bits
  function automatic logic [11:0] ref_ratio(input logic [1:0] sel);
    logic [11:0] v;
    unique case (sel)
      2'h0: v = `SPDC_REF_R0;
      2'h1: v = `SPDC_REF_R1;
      2'h2: v = `SPDC_REF_R2;
      2'h3: v = `SPDC_REF_R3;
    endcase
    return v;
  endfunction

  // Prescaler modulus, base plus sixteen while swallowing
  function automatic logic [9:0] pres_mod(input logic sel,
                                          input logic swallow);
    logic [9:0] v;
    v = sel ? `SPDC_PRE_LOW : `SPDC_PRE_HIGH;
    if (swallow) begin
      v = v + `SPDC_SWAL_STEP;
    end
    return v;
  endfunction

  // ****************************************
  // State
  // ****************************************
  spdc_dev_type r;
  spdc_dev_type n;
  logic         sclk_rise;
  logic         osc_rise;
  logic         vco_rise;
  logic         pol;
  logic [9:0]   pmod;

  // Edge detects on second and third stages only
  assign sclk_rise = r.s_clk[1] & ~r.s_clk[2];
  assign osc_rise  = r.s_osc[1] & ~r.s_osc[2];
  assign vco_rise  = r.s_vco[1] & ~r.s_vco[2];
  assign pol       = r.s_pol[1];
  assign pmod      = pres_mod(r.psel_act, r.swal_left != 5'h00);

  // Next state
  always_comb begin
    n = r;
    // Synchronisers
    n.s_clk = {r.s_clk[1:0], link.ser_clk};
    n.s_dat = {r.s_dat[0], link.ser_data};
    n.s_le  = {r.s_le[0], link.load_strobe};
    n.s_pol = {r.s_pol[0], link.pol_level};
    n.s_osc = {r.s_osc[1:0], osc_in};
    n.s_vco = {r.s_vco[1:0], vco_in};
    n.ref_tc  = 1'b0;
    n.prog_tc = 1'b0;

    // Serial shift, first bit ends up on top
    if (sclk_rise) begin
      n.shift = {r.shift[22:0], r.s_dat[1]};
    end
    // Transparent latch while strobe high
    if (r.s_le[1]) begin
      n.latch = r.shift;
    end

    // Reference counter, ratio taken at wrap
    if (osc_rise) begin
      if (r.ref_cnt == r.ref_top - 12'h001) begin
        n.ref_cnt = 12'h000;
        n.ref_top = ref_ratio(r.latch[`SPDC_REF_MSB:`SPDC_REF_LSB]);
        n.ref_tc  = 1'b1;
      end else begin
        n.ref_cnt = r.ref_cnt + 12'h001;
      end
    end

    // Pulse-swallow divider: A cycles at P+16, N-A at P
    if (vco_rise) begin
      if (r.pres_cnt == pmod - 10'h001) begin
        n.pres_cnt = 10'h000;
        if (r.main_left == 12'h001) begin
          // Reload with newly latched ratios
          n.main_left = r.latch[`SPDC_MAIN_MSB:`SPDC_MAIN_LSB];
          n.swal_left = r.latch[`SPDC_SWAL_MSB:`SPDC_SWAL_LSB];
          n.psel_act  = r.latch[`SPDC_PSEL_BIT];
          n.prog_tc   = 1'b1;
        end else begin
          n.main_left = r.main_left - 12'h001;
          if (r.swal_left != 5'h00) begin
            n.swal_left = r.swal_left - 5'h01;
          end
        end
      end else begin
        n.pres_cnt = r.pres_cnt + 10'h001;
      end
    end

    // Phase-frequency detector, cleared when both set
    n.up   = (r.up | r.ref_tc) & ~(r.up & r.down);
    n.down = (r.down | r.prog_tc) & ~(r.up & r.down);

    // Charge pump drive
    if (r.up) begin
      // Ref leads, or overlap spike near lock
      n.cp_oe  = 2'h3;
      n.cp_out = {2{pol}};
    end else if (r.down) begin
      n.cp_oe  = 2'h3;
      n.cp_out = {2{~pol}};
    end else begin
      n.cp_oe  = 2'h0;
      n.cp_out = 2'h0;
    end

    // Lock low only while one side leads
    n.lock = ~(r.up ^ r.down);
    // Monitor selects divider by polarity
    n.mon = pol ? r.ref_tc : r.prog_tc;
    // Band transistors on with their bits
    n.band_oe = r.latch[`SPDC_BAND_MSB:`SPDC_BAND_LSB];
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r           <= '0;
      r.latch     <= `SPDC_LATCH_RST;
      r.ref_top   <= `SPDC_REF_R0;
      r.main_left <= `SPDC_MAIN_MIN;
      r.lock      <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cp_out         = r.cp_out;
  assign cp_oe          = r.cp_oe;
  assign lock_indicator = r.lock;
  assign monitor_out    = r.mon;
  assign band_out       = 4'h0; // Open collector pulls low only
  assign band_oe        = r.band_oe;

endmodule // spdc_device

// file: rtl/spdc_if.sv
`timescale 1ns/10ps
interface spdc_if;
  logic ser_clk;
  logic ser_data;
  logic load_strobe;
  logic pol_out;
  logic pol_oe;
  logic pol_level;

  // Pull-up: undriven select reads high
  assign pol_level = pol_oe ? pol_out : 1'b1;

  modport ctrl (output ser_clk, ser_data, load_strobe, pol_out, pol_oe);
  modport dev  (input ser_clk, ser_data, load_strobe, pol_level);
endinterface // spdc_if

// file: rtl/spdc_pkg.sv
package spdc_pkg;
`include "spdc_defines.svh"

  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [3:0] {
    spdc_idle = 4'h1,
    spdc_lo   = 4'h2,
    spdc_hi   = 4'h4,
    spdc_load = 4'h8
  } spdc_state_type;

  // ****************************************
  // Device state
  // ****************************************
  typedef struct packed {
    logic [2:0]  s_clk;
    logic [1:0]  s_dat;
    logic [1:0]  s_le;
    logic [1:0]  s_pol;
    logic [2:0]  s_osc;
    logic [2:0]  s_vco;
    logic [23:0] shift;
    logic [23:0] latch;
    logic [11:0] ref_cnt;
    logic [11:0] ref_top;
    logic [9:0]  pres_cnt;
    logic [11:0] main_left;
    logic [4:0]  swal_left;
    logic        psel_act;
    logic        ref_tc;
    logic        prog_tc;
    logic        up;
    logic        down;
    logic [1:0]  cp_out;
    logic [1:0]  cp_oe;
    logic        lock;
    logic        mon;
    logic [3:0]  band_oe;
  } spdc_dev_type;

  // ****************************************
  // Controller state
  // ****************************************
  typedef struct packed {
    spdc_state_type state;
    logic [7:0]     half_cnt;
    logic [4:0]     bit_cnt;
    logic [23:0]    word;
    logic [23:0]    sh;
    logic           sclk;
    logic           sdat;
    logic           le;
    logic           pol_low;
    logic           done;
    logic           err;
    logic [31:0]    rdata;
  } spdc_ctl_type;

endpackage

// file: verification/spdc_bench.sv
`timescale 1ns/10ps
`include "spdc_defines.svh"
// ****************
// Bench top
// ****************
module serial_pll_divider_control_bench;
  logic        sys_clk, rst_b, osc_in, vco_in, wr, rd;
  logic [1:0]  osc_cnt, cp_out, cp_oe;
  logic [3:0]  addr, band_out, band_oe;
  logic [31:0] wdata, rdata, v;
  logic        lock_indicator, monitor_out;
  logic [27:0] rows [4];
  int          error_cnt, num_checks, cyc, n, k;

  spdc_if spdc_if_inst ();
  spdc_ctrl spdc_ctrl_inst (.link(spdc_if_inst.ctrl), .sys_clk(sys_clk),
    .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  spdc_device spdc_device_inst (.link(spdc_if_inst.dev), .sys_clk(sys_clk),
    .rst_b(rst_b), .osc_in(osc_in), .vco_in(vco_in), .cp_out(cp_out),
    .cp_oe(cp_oe), .lock_indicator(lock_indicator),
    .monitor_out(monitor_out), .band_out(band_out), .band_oe(band_oe));
  spdc_link_chk spdc_link_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .ser_clk(spdc_if_inst.ser_clk), .ser_data(spdc_if_inst.ser_data),
    .load_strobe(spdc_if_inst.load_strobe),
    .pol_out(spdc_if_inst.pol_out), .pol_oe(spdc_if_inst.pol_oe));

  // Clock, oscillator at a quarter rate, run limit
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    osc_cnt <= osc_cnt + 2'h1;
    osc_in  <= osc_cnt[1];
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end

  // Compare and report
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Register port cycles, monitor pulse count
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task count_mon;
    n = 0;
    repeat (1100) begin
      @(negedge sys_clk);
      n += int'(monitor_out);
    end
  endtask

  // Main sequence
  initial begin
    {rst_b, osc_cnt, osc_in, vco_in, wr, rd, addr, wdata} = '0;
    rows = '{{24'h020005, 4'h5}, {24'hffffea, 4'ha},
             {24'h0400f0, 4'h0}, {24'h7f0f8f, 4'hf}};
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk(band_oe, 0, "band after reset");
    chk(lock_indicator, 1, "lock after reset");
    chk(cp_oe, 0, "pump after reset");
    chk(spdc_if_inst.pol_level, 1, "open select");
    // Reference only: pump drives high, lock drops
    for (k = 0; k < 1200 && cp_oe !== 2'h3; k++) @(negedge sys_clk);
    chk(cp_out, 2'h3, "pump level open");
    chk(lock_indicator, 0, "lock with error");
    count_mon;
    chk(n > 0, 1, "monitor shows ref");
    wr_reg(`SPDC_OFS_CTRL, 32'h2);
    repeat (6) @(negedge sys_clk);
    chk(spdc_if_inst.pol_level, 0, "select low");
    chk(cp_out, 2'h0, "pump level low");
    count_mon;
    chk(n, 0, "monitor shows prog");
    // Words through the link
    foreach (rows[i]) begin
      wr_reg(`SPDC_OFS_WORD, {8'h00, rows[i][27:4]});
      wr_reg(`SPDC_OFS_CTRL, 32'h1);
      for (k = 0; k < 150; k++) begin
        rd_reg(`SPDC_OFS_STATUS);
        if (v[1]) break;
      end
      chk(v[2:0], 3'h2, "status done");
      chk(band_oe, rows[i][3:0], "band bits");
      wr_reg(`SPDC_OFS_CTRL, 32'h4);
    end
    // Main count below 32 is refused
    wr_reg(`SPDC_OFS_WORD, 32'h01f00f);
    wr_reg(`SPDC_OFS_CTRL, 32'h1);
    n = 0;
    repeat (20) begin
      @(negedge sys_clk);
      n += int'(spdc_if_inst.ser_clk);
    end
    chk(n, 0, "no link activity");
    rd_reg(`SPDC_OFS_STATUS);
    chk(v[2:0], 3'h4, "refusal flagged");
    chk(band_oe, 4'hf, "latch kept");
    rd_reg(4'hc);
    chk(v, 0, "unmapped read");
    // Second reset mid-run
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(band_oe, 0, "band in reset");
    chk(lock_indicator, 1, "lock in reset");
    chk(cp_oe, 0, "pump in reset");
    // Release again: controller idle, link quiet
    @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_reg(`SPDC_OFS_STATUS);
    chk(v, 0, "status after reset");
    chk(spdc_if_inst.load_strobe, 0, "strobe after reset");
    chk(band_oe, 0, "band after second reset");
    finish_test;
  end
endmodule // serial_pll_divider_control_bench

// file: verification/spdc_link_chk.sv
`timescale 1ns/10ps
// ****************
// Link checker
// ****************
module spdc_link_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial link
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic pol_out,
  input wire logic pol_oe
);
  logic        sclk_q_r;
  logic [4:0]  rise_cnt_r;
  logic [23:0] sh_r;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Count serial rises and mirror the shifted word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q_r   <= 1'b0;
      rise_cnt_r <= 5'h00;
      sh_r       <= 24'h000000;
    end else begin
      sclk_q_r <= ser_clk;
      if (load_strobe) begin
        rise_cnt_r <= 5'h00;
      end else if (ser_clk && !sclk_q_r) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
      if (ser_clk && !sclk_q_r) begin
        sh_r <= {sh_r[22:0], ser_data};
      end
    end
  end

  // Link timing and framing
  sclk_high_a: assert property ($rose(ser_clk) |-> ser_clk [*4])
    else $error("serial clock high half too short");
  sclk_low_a: assert property ($fell(ser_clk) |-> !ser_clk [*4])
    else $error("serial clock low half too short");
  data_hold_a: assert property (ser_clk && $past(ser_clk) |->
    $stable(ser_data)) else $error("data moved while clock high");
  strobe_len_a: assert property ($rose(load_strobe) |->
    load_strobe [*4] ##1 !load_strobe) else $error("strobe length wrong");
  strobe_clk_a: assert property (load_strobe |-> !ser_clk)
    else $error("clock high during strobe");
  bit_count_a: assert property ($rose(load_strobe) |->
    rise_cnt_r == 5'h18) else $error("word not 24 bits");
  main_min_a: assert property ($rose(load_strobe) |->
    sh_r[23:12] >= 12'h020) else $error("main count below 32");
  pol_drive_a: assert property (pol_oe |-> !pol_out)
    else $error("select driven high");

  // Main scenarios
  cov_load: cover property ($rose(load_strobe));
  cov_pol: cover property ($rose(pol_oe));
  cov_sclk: cover property ($rose(ser_clk));
endmodule // spdc_link_chk
